// ---- src/bbx_pkg.sv ----
// package: constants and types of the branch and bit executor
`default_nettype none
package bbx_pkg;
  // ****************************************
  // bus map (byte offsets)
  // ****************************************
  localparam int         ADR_W     = 12;
  localparam logic [11:0] OFF_INSTR = 12'h000;
  localparam logic [11:0] OFF_FLAGS = 12'h004;
  localparam logic [11:0] OFF_PC    = 12'h008;
  localparam logic [11:0] OFF_CYC   = 12'h00c;
  localparam logic [11:0] OFF_GPR   = 12'h100;
  localparam logic [11:0] OFF_IO    = 12'h200;

  // ****************************************
  // status flag positions and reset values
  // ****************************************
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] REG_RST   = 8'h00;

  // ****************************************
  // instruction word fields and cycle costs
  // ****************************************
  localparam int         OP_LSB  = 0;
  localparam int         OP_W    = 6;
  localparam int         SEL_LSB = 8;
  localparam int         RD_LSB  = 16;
  localparam int         K_LSB   = 24;
  localparam int         K_W     = 7;
  localparam logic [31:0] CYC_SHORT = 32'h0000_0001;
  localparam logic [31:0] CYC_LONG  = 32'h0000_0002;

  typedef enum logic [5:0] {
    OP_BRANCH_ON_NONNEGATIVE, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
    OP_BRANCH_HALFCARRY_SET, OP_BRANCH_HALFCARRY_CLEAR,
    OP_BRANCH_TRANSFER_SET, OP_BRANCH_TRANSFER_CLEAR,
    OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR,
    OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED,
    OP_BRANCH_STATUS_BIT_SET, OP_BRANCH_STATUS_BIT_CLEAR,
    OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
    OP_ROTATE_RIGHT_VIA_CARRY, OP_ARITH_SHIFT_RIGHT, OP_NIBBLE_SWAP,
    OP_FLAG_SET_GENERIC, OP_FLAG_CLEAR_GENERIC,
    OP_BIT_TO_TRANSFER_FLAG, OP_TRANSFER_FLAG_TO_BIT,
    OP_CARRY_FLAG_SET, OP_CARRY_FLAG_CLEAR,
    OP_NEGATIVE_FLAG_SET, OP_NEGATIVE_FLAG_CLEAR,
    OP_ZERO_FLAG_SET, OP_ZERO_FLAG_CLEAR,
    OP_GLOBAL_IRQ_ENABLE, OP_GLOBAL_IRQ_DISABLE,
    OP_SIGN_FLAG_SET, OP_SIGN_FLAG_CLEAR, OP_OVERFLOW_FLAG_SET
  } bbx_op_t;

  typedef enum {ST_IDLE, ST_SECOND} bbx_state_t;
endpackage
`default_nettype wire

// ---- src/bbx_alu.sv ----
// single-cycle data and flag operations of the executor
`default_nettype none
module bbx_alu (
  input  wire bbx_pkg::bbx_op_t op_i,
  input  wire logic [7:0]       opnd_i,
  input  wire logic [2:0]       bit_i,
  input  wire logic [7:0]       flags_i,
  output logic [7:0]            res_o,
  output logic [7:0]            flags_o,
  output logic                  wr_o
);
  // ****************************************
  // result and flag update
  // ****************************************
  // unaffected flags pass through unchanged
  always_comb begin
    res_o   = opnd_i;
    flags_o = flags_i;
    wr_o    = 1'b0;
    case (op_i)
      bbx_pkg::OP_ROTATE_RIGHT_VIA_CARRY, bbx_pkg::OP_ARITH_SHIFT_RIGHT: begin
        // top bit from carry or kept sign
        res_o[7] = (op_i == bbx_pkg::OP_ROTATE_RIGHT_VIA_CARRY) ?
                   flags_i[bbx_pkg::FLAG_C] : opnd_i[7];
        res_o[6:0] = opnd_i[7:1];
        wr_o = 1'b1;
        flags_o[bbx_pkg::FLAG_C] = opnd_i[0];
        flags_o[bbx_pkg::FLAG_N] = res_o[7];
        flags_o[bbx_pkg::FLAG_V] = res_o[7] ^ opnd_i[0];
        flags_o[bbx_pkg::FLAG_Z] = (res_o == 8'h00);
      end
      bbx_pkg::OP_NIBBLE_SWAP: begin
        res_o = {opnd_i[3:0], opnd_i[7:4]};
        wr_o  = 1'b1;
      end
      bbx_pkg::OP_BIT_TO_TRANSFER_FLAG: flags_o[bbx_pkg::FLAG_T] = opnd_i[bit_i];
      bbx_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
        res_o[bit_i] = flags_i[bbx_pkg::FLAG_T];
        wr_o = 1'b1;
      end
      bbx_pkg::OP_FLAG_SET_GENERIC:   flags_o[bit_i] = 1'b1;
      bbx_pkg::OP_FLAG_CLEAR_GENERIC: flags_o[bit_i] = 1'b0;
      bbx_pkg::OP_CARRY_FLAG_SET:      flags_o[bbx_pkg::FLAG_C] = 1'b1;
      bbx_pkg::OP_CARRY_FLAG_CLEAR:    flags_o[bbx_pkg::FLAG_C] = 1'b0;
      bbx_pkg::OP_NEGATIVE_FLAG_SET:   flags_o[bbx_pkg::FLAG_N] = 1'b1;
      bbx_pkg::OP_NEGATIVE_FLAG_CLEAR: flags_o[bbx_pkg::FLAG_N] = 1'b0;
      bbx_pkg::OP_ZERO_FLAG_SET:       flags_o[bbx_pkg::FLAG_Z] = 1'b1;
      bbx_pkg::OP_ZERO_FLAG_CLEAR:     flags_o[bbx_pkg::FLAG_Z] = 1'b0;
      bbx_pkg::OP_GLOBAL_IRQ_ENABLE:   flags_o[bbx_pkg::FLAG_I] = 1'b1;
      bbx_pkg::OP_GLOBAL_IRQ_DISABLE:  flags_o[bbx_pkg::FLAG_I] = 1'b0;
      bbx_pkg::OP_SIGN_FLAG_SET:       flags_o[bbx_pkg::FLAG_S] = 1'b1;
      bbx_pkg::OP_SIGN_FLAG_CLEAR:     flags_o[bbx_pkg::FLAG_S] = 1'b0;
      bbx_pkg::OP_OVERFLOW_FLAG_SET:   flags_o[bbx_pkg::FLAG_V] = 1'b1;
      default: ;
    endcase
  end
endmodule
`default_nettype wire

// ---- src/bbx_exec.sv ----
// branch and bit instruction executor with a wishbone slave
// Notes on behaviour
// - branch on nonnegative jumps to pc+k+1 when N is 0
// - signed ge branch jumps when N xor V is 0
// - signed lt branch jumps when N xor V is 1
// - half carry set branch jumps when H is 1
// - half carry clear branch jumps when H is 0
// - transfer set branch jumps when T is 1
// - transfer clear branch jumps when T is 0
// - overflow set branch jumps when V is 1
// - overflow clear branch jumps when V is 0
// - irq enabled branch jumps when I is 1
// - irq disabled branch jumps when I is 0
// - io bit set forces one io bit high in two cycles
// - io bit clear forces one io bit low in two cycles
// - rotate right through carry, updates Z C N V
// - arithmetic shift right keeps bit 7, updates Z C N V
// - bit store copies a register bit into T only
// - bit load copies T into a register bit, flags kept
// - dedicated set and clear of C N Z I S, one cycle
// - overflow set writes V to one, nothing else
// - named branches other than signed ge and lt act as the generic flag bit branch
`default_nettype none
module bbx_exec #(
  parameter int PC_W = 12,
  parameter int IO_N = 32
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic [PC_W-1:0]  pc_o,
  output logic [7:0]       flags_o
);
  // ****************************************
  // parameter check
  // ****************************************
  if (PC_W < 8 || PC_W > 32 || IO_N < 1 || IO_N > 32) begin : g_bad_param
    $error("bbx_exec: PC_W or IO_N out of range");
  end

  // ****************************************
  // state
  // ****************************************
  bbx_pkg::bbx_state_t st_q;
  logic                ack_q;
  logic [31:0]         dat_q;
  logic [PC_W-1:0]     pc_q;
  logic [PC_W-1:0]     tgt_q;
  logic [7:0]          flags_q;
  logic [7:0]          gpr_q [32];
  logic [7:0]          io_q [IO_N];
  logic [31:0]         instr_q;
  logic [31:0]         cyc_q;
  logic                br_pend_q;
  logic                io_pend_q;
  logic                io_val_q;
  logic [4:0]          io_idx_q;
  logic [2:0]          io_bit_q;
  logic [7:0]          rmw_q;

  // ****************************************
  // decode
  // ****************************************
  logic             req;
  logic             wr;
  logic             go;
  bbx_pkg::bbx_op_t op;
  logic [2:0]       sel;
  logic [4:0]       rd;
  logic [6:0]       k;
  logic [PC_W-1:0]  tgt;
  logic [1:0]       br;
  logic             is_io;
  logic             io_ok;
  logic             long_op;
  logic [7:0]       opnd_w;
  logic [7:0]       alu_res;
  logic [7:0]       alu_flags;
  logic             alu_wr;
  logic [31:0]      rdata;
  logic [4:0]       widx;

  // branch decode: {is branch, condition met}
  function automatic logic [1:0] br_dec(input bbx_pkg::bbx_op_t o,
                                        input logic [2:0] s,
                                        input logic [7:0] f);
    logic       hit;
    logic       want;
    logic       sgn;
    logic [2:0] idx;
    logic       cond;
    hit  = 1'b1;
    want = 1'b1;
    sgn  = 1'b0;
    idx  = s;
    case (o)
      bbx_pkg::OP_BRANCH_ON_NONNEGATIVE: begin
        idx  = bbx_pkg::FLAG_N;
        want = 1'b0;
      end
      bbx_pkg::OP_BRANCH_SIGNED_GE: begin
        sgn  = 1'b1;
        want = 1'b0;
      end
      bbx_pkg::OP_BRANCH_SIGNED_LT: sgn = 1'b1;
      bbx_pkg::OP_BRANCH_HALFCARRY_SET: idx = bbx_pkg::FLAG_H;
      bbx_pkg::OP_BRANCH_HALFCARRY_CLEAR: begin
        idx  = bbx_pkg::FLAG_H;
        want = 1'b0;
      end
      bbx_pkg::OP_BRANCH_TRANSFER_SET: idx = bbx_pkg::FLAG_T;
      bbx_pkg::OP_BRANCH_TRANSFER_CLEAR: begin
        idx  = bbx_pkg::FLAG_T;
        want = 1'b0;
      end
      bbx_pkg::OP_BRANCH_OVERFLOW_SET: idx = bbx_pkg::FLAG_V;
      bbx_pkg::OP_BRANCH_OVERFLOW_CLEAR: begin
        idx  = bbx_pkg::FLAG_V;
        want = 1'b0;
      end
      bbx_pkg::OP_BRANCH_IRQ_ENABLED: idx = bbx_pkg::FLAG_I;
      bbx_pkg::OP_BRANCH_IRQ_DISABLED: begin
        idx  = bbx_pkg::FLAG_I;
        want = 1'b0;
      end
      bbx_pkg::OP_BRANCH_STATUS_BIT_SET: ;
      bbx_pkg::OP_BRANCH_STATUS_BIT_CLEAR: want = 1'b0;
      default: hit = 1'b0;
    endcase
    // named branches other than signed ge and lt reduce to one status bit test
    cond = sgn ? (f[bbx_pkg::FLAG_N] ^ f[bbx_pkg::FLAG_V]) : f[idx];
    br_dec = {hit, hit & (cond == want)};
  endfunction

  // bus request qualification and instruction fields
  always_comb begin
    req   = wb_cyc_i & wb_stb_i & ~ack_q & (st_q == bbx_pkg::ST_IDLE);
    wr    = req & wb_we_i;
    go    = wr & (wb_adr_i[11:2] == bbx_pkg::OFF_INSTR[11:2]) & (wb_sel_i == 4'hf);
    op    = bbx_pkg::bbx_op_t'(wb_dat_i[bbx_pkg::OP_LSB +: bbx_pkg::OP_W]);
    sel   = wb_dat_i[bbx_pkg::SEL_LSB +: 3];
    rd    = wb_dat_i[bbx_pkg::RD_LSB +: 5];
    k     = wb_dat_i[bbx_pkg::K_LSB +: bbx_pkg::K_W];
    widx  = wb_adr_i[6:2];
    tgt   = pc_q + {{(PC_W-bbx_pkg::K_W){k[6]}}, k} + PC_W'(1);
    br    = br_dec(op, sel, flags_q);
    is_io = (op == bbx_pkg::OP_IO_BIT_SET) | (op == bbx_pkg::OP_IO_BIT_CLEAR);
    io_ok = (32'(rd) < IO_N);
    long_op = br[0] | is_io;
    opnd_w  = gpr_q[rd];
  end

  // shift, swap, bit and flag operations
  bbx_alu u_alu (
    .op_i    (op),
    .opnd_i  (opnd_w),
    .bit_i   (sel),
    .flags_i (flags_q),
    .res_o   (alu_res),
    .flags_o (alu_flags),
    .wr_o    (alu_wr)
  );

  // read mux; unmapped words read zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (wb_adr_i[11:8] == bbx_pkg::OFF_GPR[11:8]) begin
      rdata[7:0] = gpr_q[widx];
    end else if (wb_adr_i[11:8] == bbx_pkg::OFF_IO[11:8]) begin
      if (32'(widx) < IO_N) begin
        rdata[7:0] = io_q[widx];
      end
    end else if (wb_adr_i[11:2] == bbx_pkg::OFF_INSTR[11:2]) begin
      rdata = instr_q;
    end else if (wb_adr_i[11:2] == bbx_pkg::OFF_FLAGS[11:2]) begin
      rdata[7:0] = flags_q;
    end else if (wb_adr_i[11:2] == bbx_pkg::OFF_PC[11:2]) begin
      rdata[PC_W-1:0] = pc_q;
    end else if (wb_adr_i[11:2] == bbx_pkg::OFF_CYC[11:2]) begin
      rdata = cyc_q;
    end
  end

  // ****************************************
  // sequencing and bus answer
  // ****************************************
  // two-cycle work holds the ack back one edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q  <= bbx_pkg::ST_IDLE;
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= 1'b0;
      case (st_q)
        bbx_pkg::ST_IDLE: begin
          if (go && long_op) begin
            st_q <= bbx_pkg::ST_SECOND;
          end else if (req) begin
            ack_q <= 1'b1;
          end
        end
        bbx_pkg::ST_SECOND: begin
          st_q  <= bbx_pkg::ST_IDLE;
          ack_q <= 1'b1;
        end
        default: st_q <= bbx_pkg::ST_IDLE;
      endcase
    end
  end

  // read data captured on the request edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (ce_i && req && !wb_we_i) begin
      dat_q <= rdata;
    end
  end

  // ****************************************
  // program counter
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_q <= '0;
    end else if (ce_i) begin
      if (go && !br[0]) begin
        pc_q <= pc_q + PC_W'(1);
      end else if (st_q == bbx_pkg::ST_SECOND && br_pend_q) begin
        pc_q <= tgt_q;
      end else if (wr && wb_adr_i[11:2] == bbx_pkg::OFF_PC[11:2] && wb_sel_i[1:0] == 2'h3) begin
        pc_q <= wb_dat_i[PC_W-1:0];
      end
    end
  end

  // pending second-cycle work
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      br_pend_q <= 1'b0;
      io_pend_q <= 1'b0;
      io_val_q  <= 1'b0;
      io_idx_q  <= 5'h00;
      io_bit_q  <= 3'h0;
      tgt_q     <= '0;
      rmw_q     <= bbx_pkg::REG_RST;
    end else if (ce_i && go) begin
      br_pend_q <= br[0];
      io_pend_q <= is_io & io_ok;
      io_val_q  <= (op == bbx_pkg::OP_IO_BIT_SET);
      io_idx_q  <= rd;
      io_bit_q  <= sel;
      tgt_q     <= tgt;
      rmw_q     <= io_ok ? io_q[rd] : bbx_pkg::REG_RST;
    end
  end

  // ****************************************
  // status flags and register files
  // ****************************************
  // io bit ops and branches leave the flags alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= bbx_pkg::FLAGS_RST;
    end else if (ce_i) begin
      if (go) begin
        flags_q <= alu_flags;
      end else if (wr && wb_adr_i[11:2] == bbx_pkg::OFF_FLAGS[11:2] && wb_sel_i[0]) begin
        flags_q <= wb_dat_i[7:0];
      end
    end
  end

  // working registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 32; i++) begin
        gpr_q[i] <= bbx_pkg::REG_RST;
      end
    end else if (ce_i) begin
      if (go && alu_wr) begin
        gpr_q[rd] <= alu_res;
      end else if (wr && wb_adr_i[11:8] == bbx_pkg::OFF_GPR[11:8] && wb_sel_i[0]) begin
        gpr_q[widx] <= wb_dat_i[7:0];
      end
    end
  end

  // io registers, read-modify-write in the second cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < IO_N; i++) begin
        io_q[i] <= bbx_pkg::REG_RST;
      end
    end else if (ce_i) begin
      if (st_q == bbx_pkg::ST_SECOND && io_pend_q) begin
        io_q[io_idx_q]           <= rmw_q;
        io_q[io_idx_q][io_bit_q] <= io_val_q;
      end else if (wr && wb_adr_i[11:8] == bbx_pkg::OFF_IO[11:8] && wb_sel_i[0] && 32'(widx) < IO_N) begin
        io_q[widx] <= wb_dat_i[7:0];
      end
    end
  end

  // last instruction and executed cycle count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_q <= 32'h0000_0000;
      cyc_q   <= 32'h0000_0000;
    end else if (ce_i && go) begin
      instr_q <= wb_dat_i;
      cyc_q   <= cyc_q + (long_op ? bbx_pkg::CYC_LONG : bbx_pkg::CYC_SHORT);
    end
  end

  // outputs
  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign pc_o     = pc_q;
  assign flags_o  = flags_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  untaken_step_a:
    assert property (go && br[1] && !br[0] |=> wb_ack_o && pc_q == PC_W'($past(pc_q) + 1'b1))
    else $error("untaken branch did not step pc");
  taken_jump_a:
    assert property (go && br[0] |=> !wb_ack_o ##1 wb_ack_o && pc_q == $past(tgt, 2))
    else $error("taken branch target or timing wrong");
  plus_branch_a:
    assert property (go && op == bbx_pkg::OP_BRANCH_ON_NONNEGATIVE
                     |=> (st_q == bbx_pkg::ST_SECOND) == !$past(flags_q[bbx_pkg::FLAG_N]))
    else $error("plus branch decision wrong");
  signed_ge_a:
    assert property (go && op == bbx_pkg::OP_BRANCH_SIGNED_GE && flags_q[bbx_pkg::FLAG_N] == flags_q[bbx_pkg::FLAG_V]
                     |=> st_q == bbx_pkg::ST_SECOND)
    else $error("signed ge branch not taken");
  signed_lt_a:
    assert property (go && op == bbx_pkg::OP_BRANCH_SIGNED_LT && flags_q[bbx_pkg::FLAG_N] == flags_q[bbx_pkg::FLAG_V]
                     |=> wb_ack_o && st_q == bbx_pkg::ST_IDLE)
    else $error("signed lt branch taken wrongly");
  io_set_a:
    assert property (go && op == bbx_pkg::OP_IO_BIT_SET && io_ok
                     |=> !wb_ack_o ##1 wb_ack_o && io_q[io_idx_q][io_bit_q] && flags_q == $past(flags_q, 2))
    else $error("io bit set failed");
  io_clear_a:
    assert property (go && op == bbx_pkg::OP_IO_BIT_CLEAR && io_ok
                     |=> !wb_ack_o ##1 wb_ack_o && !io_q[io_idx_q][io_bit_q] && flags_q == $past(flags_q, 2))
    else $error("io bit clear failed");
  rotate_right_a:
    assert property (go && op == bbx_pkg::OP_ROTATE_RIGHT_VIA_CARRY
                     |=> gpr_q[$past(rd)][7] == $past(flags_q[bbx_pkg::FLAG_C])
                         && flags_q[bbx_pkg::FLAG_C] == $past(opnd_w[0]))
    else $error("rotate right result wrong");
  shift_sign_a:
    assert property (go && op == bbx_pkg::OP_ARITH_SHIFT_RIGHT
                     |=> gpr_q[$past(rd)][7] == $past(opnd_w[7]) && flags_q[bbx_pkg::FLAG_C] == $past(opnd_w[0]))
    else $error("arithmetic shift keeps no sign");
  bit_store_a:
    assert property (go && op == bbx_pkg::OP_BIT_TO_TRANSFER_FLAG
                     |=> flags_q[bbx_pkg::FLAG_T] == $past(opnd_w[sel]))
    else $error("bit store wrong");
  nibble_swap_a:
    assert property (go && op == bbx_pkg::OP_NIBBLE_SWAP
                     |=> gpr_q[$past(rd)] == {$past(opnd_w[3:0]), $past(opnd_w[7:4])} && $stable(flags_q))
    else $error("nibble swap wrong");
  flag_set_a:
    assert property (go && op == bbx_pkg::OP_FLAG_SET_GENERIC
                     |=> flags_q == ($past(flags_q) | (8'h01 << $past(sel))))
    else $error("generic flag set wrong");

  taken_branch_c: cover property (go && br[0] ##2 wb_ack_o);
  io_bit_set_c: cover property (go && op == bbx_pkg::OP_IO_BIT_SET && io_ok);
  rotate_c: cover property (go && op == bbx_pkg::OP_ROTATE_RIGHT_VIA_CARRY ##1 wb_ack_o);
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking testbench of the branch and bit executor
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
`define chk(nm, got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
  // ****************************************
  // signals and reference state
  // ****************************************
  typedef struct {logic we; int lat; logic [31:0] dat; logic [11:0] pc; logic [7:0] fl;} bbx_note_t;
  localparam int         LIMIT     = 30000;
  localparam logic [2:0] BPOS [8]  = '{3'h5, 3'h5, 3'h6, 3'h6, 3'h3, 3'h3, 3'h7, 3'h7};
  localparam logic [2:0] FPOS [11] = '{3'h0, 3'h0, 3'h2, 3'h2, 3'h1, 3'h1, 3'h7, 3'h7, 3'h4, 3'h4, 3'h3};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i  = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [11:0] adr   = 12'h000;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] dat   = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [11:0] pc_o;
  logic [7:0]  flags_o;
  logic [7:0]  fl;
  logic [7:0]  gpr [32];
  logic [7:0]  io [32];
  logic [11:0] pc;
  logic [31:0] ncyc;
  logic [31:0] last;
  logic [31:0] w;
  bbx_note_t   notes [$];
  bbx_note_t   e;
  int          errors = 0;
  int          n_checks = 0;
  int          wt = 0;
  int          ticks = 0;

  bbx_exec #(.PC_W(12), .IO_N(32)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pc_o(pc_o), .flags_o(flags_o)
  );

  // 250 MHz clock
  always #2 clk_i = ~clk_i;

  // ****************************************
  // verdict and hang guard
  // ****************************************
  task automatic results();
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // cut a hung run short
  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    if (ticks == LIMIT) begin
      errors++;
      results();
    end
  end

  // ****************************************
  // bus driver and answer monitor
  // ****************************************
  task automatic bus(input logic w_e, input logic [11:0] a, input logic [3:0] s,
                     input logic [31:0] d, input int lat);
    notes.push_back('{w_e, lat, d, pc, fl});
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w_e;
    adr <= a;
    sel <= s;
    dat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // oldest note against each acknowledged answer
  always @(posedge clk_i) begin
    if (!rst_i && cyc && stb) wt = wt + 1;
    if (!rst_i && wb_ack_o === 1'b1) begin
      e = notes.pop_front();
      `chk("ack_latency", wt, e.lat + 1)
      `chk("pc_o", pc_o, e.pc)
      `chk("flags_o", flags_o, e.fl)
      if (!e.we) `chk("read_data", wb_dat_o, e.dat)
      wt = 0;
    end
  end

  // ****************************************
  // reference model of one instruction
  // ****************************************
  function automatic int exec_model(input logic [31:0] iw);
    logic [5:0] op;
    logic [2:0] b;
    logic [4:0] d;
    logic [7:0] r;
    logic [7:0] o;
    logic       tk;
    int         lat;
    op = iw[5:0];
    b = iw[10:8];
    d = iw[20:16];
    o = gpr[d];
    r = o;
    tk = 1'b0;
    case (op) inside
      6'h00: tk = !fl[2];
      6'h01: tk = !(fl[2] ^ fl[3]);
      6'h02: tk = fl[2] ^ fl[3];
      [6'h03:6'h0a]: tk = (fl[BPOS[op - 6'h03]] == op[0]);
      [6'h0b:6'h0c]: tk = (fl[b] == op[0]);
      [6'h0d:6'h0e]: io[d][b] = (op == 6'h0d);
      6'h0f: r = {fl[0], o[7:1]};
      6'h10: r = {o[7], o[7:1]};
      6'h11: r = {o[3:0], o[7:4]};
      [6'h12:6'h13]: fl[b] = (op == 6'h12);
      6'h14: fl[6] = o[b];
      6'h15: r[b] = fl[6];
      default: fl[FPOS[op - 6'h16]] = !op[0];
    endcase
    // shifts update zero, carry, negative and overflow
    if (op inside {6'h0f, 6'h10}) begin
      fl[0] = o[0];
      fl[1] = (r == 8'h00);
      fl[2] = r[7];
      fl[3] = r[7] ^ o[0];
    end
    gpr[d] = r;
    lat = (tk || op inside {6'h0d, 6'h0e}) ? 2 : 1;
    pc = tk ? pc + {{5{iw[30]}}, iw[30:24]} + 12'h001 : pc + 12'h001;
    ncyc = ncyc + lat;
    last = iw;
    return lat;
  endfunction

  // read back flags, pc, one register pair, count and last word
  task automatic chkall(input logic [4:0] d);
    bus(1'b0, 12'h004, 4'hf, {24'h0, fl}, 1);
    bus(1'b0, 12'h008, 4'hf, {20'h0, pc}, 1);
    bus(1'b0, {5'h02, d, 2'h0}, 4'hf, {24'h0, gpr[d]}, 1);
    bus(1'b0, {5'h04, d, 2'h0}, 4'hf, {24'h0, io[d]}, 1);
    bus(1'b0, 12'h00c, 4'hf, ncyc, 1);
    bus(1'b0, 12'h000, 4'hf, last, 1);
  endtask

  // reference state after a reset
  task automatic mzero();
    fl = bbx_pkg::FLAGS_RST;
    pc = 12'h000;
    ncyc = 32'h0;
    last = 32'h0;
    foreach (gpr[i]) begin
      gpr[i] = bbx_pkg::REG_RST;
      io[i] = bbx_pkg::REG_RST;
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h65acfcbb));
    mzero();
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chkall(5'h1f);
    // every opcode with random flags, pc, register and offset
    for (int rep = 0; rep < 6; rep++) begin
      for (int op = 0; op < 33; op++) begin
        w = $urandom();
        w[5:0] = op[5:0];
        dat <= $urandom();
        fl = 8'($urandom());
        bus(1'b1, 12'h004, 4'h1, {24'($urandom()), fl}, 1);
        pc = (rep == 0) ? 12'hfff : 12'($urandom());
        bus(1'b1, 12'h008, 4'h3, {20'h0, pc}, 1);
        gpr[w[20:16]] = 8'($urandom());
        bus(1'b1, {5'h02, w[20:16], 2'h0}, 4'h1, {24'h0, gpr[w[20:16]]}, 1);
        io[w[20:16]] = 8'($urandom());
        bus(1'b1, {5'h04, w[20:16], 2'h0}, 4'h1, {24'h0, io[w[20:16]]}, 1);
        bus(1'b1, 12'h000, 4'hf, w, exec_model(w));
        chkall(w[20:16]);
      end
    end
    // unmapped, read-only and partial-enable accesses leave state alone
    bus(1'b1, 12'h300, 4'hf, 32'hffff_ffff, 1);
    bus(1'b0, 12'h300, 4'hf, 32'h0, 1);
    bus(1'b0, 12'h010, 4'hf, 32'h0, 1);
    bus(1'b1, 12'h00c, 4'hf, 32'h0, 1);
    bus(1'b1, 12'h000, 4'h7, 32'h0000_0016, 1);
    chkall(5'h00);
    // low clock enable holds off a standing flags write for three edges
    fl = ~fl;
    fork
      bus(1'b1, 12'h004, 4'h1, {24'h0, fl}, 4);
      begin
        @(posedge clk_i);
        ce_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        ce_i <= 1'b1;
      end
    join
    // second reset in mid-run
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    mzero();
    chkall(5'h03);
    results();
  end
endmodule
`default_nettype wire
